// *** hw/csi_pkg.sv ***
package csi_pkg;
  // register byte offsets on the software bus
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_FMT = 5'h04;
  localparam logic [4:0] OFS_LEN = 5'h08;
  localparam logic [4:0] OFS_FLAG = 5'h0c;
  localparam logic [4:0] OFS_TX = 5'h10;
  localparam logic [4:0] OFS_RX = 5'h14;
  // serial master end, own command registers
  localparam logic [4:0] OFS_M_CTRL = 5'h00;
  localparam logic [4:0] OFS_M_TX = 5'h04;
  localparam logic [4:0] OFS_M_RX = 5'h08;
  localparam logic [4:0] OFS_M_STAT = 5'h0c;
  // mode_control_reg fields
  localparam int MC_POWER = 7;
  localparam int MC_TXE = 6;
  localparam int MC_RXE = 5;
  localparam int MC_ORDER = 4;
  localparam int MC_CONT = 1;
  localparam int MC_SCE = 0;
  // clock_format_reg fields
  localparam int FMT_CKP = 4;
  localparam int FMT_DAP = 3;
  localparam logic [2:0] CKS_EXTERNAL = 3'h7;
  // flag_reg fields
  localparam int FLAG_TSF = 7;
  localparam int FLAG_OVE = 0;
  // master ctrl and status fields
  localparam int MCTRL_CKP = 4;
  localparam int MSTAT_BUSY = 0;
  localparam int MSTAT_RXV = 1;
  // word length: field 0 means eight bits
  localparam logic [4:0] LEN_ZERO_BITS = 5'h08;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  // serial clock made by the master end
  localparam int MCLK_MHZ = 200;
  localparam int SCK_HALF_NS = 80;
  localparam logic [4:0] SCK_HALF_CYC = 5'(SCK_HALF_NS * MCLK_MHZ / 1000);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b11
  } xfer_state_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_DRIVE = 2'b01,
    M_SAMPLE = 2'b11
  } master_state_e;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [7:0] mode;
    logic [4:0] fmt;
    logic [3:0] len;
    logic tsf;
    logic ove;
    logic [15:0] txh;
    logic tx_full;
    logic [15:0] rxh;
    logic rx_unread;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic si_bit;
    logic pend;
    xfer_state_e st;
    logic [2:0] sck_sync;
    logic [1:0] si_sync;
    logic so;
    logic irq_rx;
    logic irq_tx;
  } dev_s;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [3:0] len;
    logic ckp;
    logic rxv;
    logic [15:0] rx;
    logic [15:0] sh;
    logic [4:0] bits;
    logic [4:0] div;
    master_state_e st;
    logic sclk;
    logic si;
    logic [1:0] so_sync;
  } mst_s;
endpackage

// *** hw/csi_link_if.sv ***
interface csi_link_if;
  logic serial_clock_pin;
  logic serial_in_pin;
  logic serial_out_pin;

  modport device (
    input serial_clock_pin,
    input serial_in_pin,
    output serial_out_pin
  );

  modport master (
    output serial_clock_pin,
    output serial_in_pin,
    input serial_out_pin
  );
endinterface

// *** hw/serial_master_end.sv ***
module serial_master_end
  import csi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // serial link
  csi_link_if.master lnk
);
  mst_s q;
  mst_s d;
  logic wr;
  logic rd;
  logic [4:0] n;
  logic so;

  // next state; one bit is a drive half followed by a sample half
  always_comb begin
    d = q;
    wr = write & ~q.wreq;
    rd = read & ~q.wreq;
    n = (q.len == 4'h0) ? LEN_ZERO_BITS : {1'b0, q.len};
    so = q.so_sync[1];
    d.so_sync = {q.so_sync[0], lnk.serial_out_pin};
    d.wreq = ~(q.wreq & (read | write));
    if (address == OFS_M_CTRL) begin
      d.rdata = 32'({q.ckp, q.len});
    end else if (address == OFS_M_RX) begin
      d.rdata = 32'(q.rx);
    end else if (address == OFS_M_STAT) begin
      d.rdata = 32'({q.rxv, q.st != M_IDLE});
    end else begin
      d.rdata = 32'h0000_0000;
    end
    if (rd && address == OFS_M_RX) begin
      d.rxv = 1'b0;
    end
    // a word written while busy is dropped; software polls busy first
    if (wr && q.st == M_IDLE) begin
      if (address == OFS_M_CTRL) begin
        d.len = writedata[3:0];
        d.ckp = writedata[MCTRL_CKP];
        d.sclk = ~writedata[MCTRL_CKP];
      end else if (address == OFS_M_TX) begin
        d.sh = writedata[15:0];
        d.bits = n;
        d.div = SCK_HALF_CYC;
        d.st = M_DRIVE;
        d.sclk = q.ckp;
        d.si = writedata[4'(n - 5'd1)];
      end
    end
    case (q.st)
      M_DRIVE: begin
        d.div = q.div - 5'd1;
        if (q.div == 5'd1) begin
          d.div = SCK_HALF_CYC;
          d.sclk = ~q.ckp;
          d.sh = {q.sh[14:0], so};
          d.bits = q.bits - 5'd1;
          d.st = M_SAMPLE;
        end
      end
      M_SAMPLE: begin
        d.div = q.div - 5'd1;
        if (q.div == 5'd1) begin
          if (q.bits == 5'd0) begin
            d.rx = q.sh & ~(ALL_ONES << n);
            d.rxv = 1'b1;
            d.st = M_IDLE;
          end else begin
            d.div = SCK_HALF_CYC;
            d.sclk = q.ckp;
            d.si = q.sh[4'(n - 5'd1)];
            d.st = M_DRIVE;
          end
        end
      end
      default: begin
        // a word started this cycle keeps its freshly loaded half period
        if (d.st == M_IDLE) begin
          d.div = 5'd0;
        end
      end
    endcase
  end

  // state register; idle clock level is high for polarity 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.wreq <= 1'b1;
      q.sclk <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign readdata = q.rdata;
  assign waitrequest = q.wreq;
  assign lnk.serial_clock_pin = q.sclk;
  assign lnk.serial_in_pin = q.si;
endmodule

// *** hw/clocked_serial_unit.sv ***
module clocked_serial_unit
  import csi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // interrupt request pulses
  output logic rx_done_irq,
  output logic tx_ready_irq,
  // serial link
  csi_link_if.device lnk
);
  dev_s q;
  dev_s d;
  logic wr;
  logic rd;
  logic [4:0] nbits;
  logic pwr;
  logic txe;
  logic rxe;
  logic lsb_first;
  logic cont;
  logic ext_clk;
  logic rise;
  logic fall;
  logic smp_edge;
  logic drv_edge;
  logic [15:0] word;

  // shift one bit into the shifter in the chosen order
  function automatic logic [15:0] shift_in(logic [15:0] s, logic b,
                                           logic lsb, logic [4:0] n);
    logic [15:0] r;
    r = lsb ? (s >> 1) : {s[14:0], b};
    if (lsb) begin
      r[4'(n - 5'd1)] = b;
    end
    return r;
  endfunction

  // whole next-state computation
  always_comb begin
    d = q;
    d.irq_rx = 1'b0;
    d.irq_tx = 1'b0;
    wr = write & ~q.wreq;
    rd = read & ~q.wreq;
    pwr = q.mode[MC_POWER];
    txe = q.mode[MC_TXE];
    rxe = q.mode[MC_RXE];
    lsb_first = q.mode[MC_ORDER];
    cont = q.mode[MC_CONT];
    ext_clk = q.fmt[2:0] == CKS_EXTERNAL;
    nbits = (q.len == 4'h0) ? LEN_ZERO_BITS : {1'b0, q.len};
    word = 16'h0000;

    // stage one of each synchroniser feeds only stage two
    d.sck_sync = {q.sck_sync[1:0], lnk.serial_clock_pin};
    d.si_sync = {q.si_sync[0], lnk.serial_in_pin};
    rise = q.sck_sync[1] & ~q.sck_sync[2];
    fall = ~q.sck_sync[1] & q.sck_sync[2];
    // polarity 0 samples on the rising edge, drives on the falling one
    smp_edge = ext_clk & (q.fmt[FMT_CKP] ? fall : rise);
    drv_edge = ext_clk & (q.fmt[FMT_CKP] ? rise : fall);

    // one wait cycle per access keeps read data a register output
    d.wreq = ~(q.wreq & (read | write));
    if (address == OFS_MODE) begin
      d.rdata = 32'(q.mode);
    end else if (address == OFS_FMT) begin
      d.rdata = 32'(q.fmt);
    end else if (address == OFS_LEN) begin
      d.rdata = 32'(q.len);
    end else if (address == OFS_FLAG) begin
      d.rdata = 32'({q.tsf, 6'h00, q.ove});
    end else if (address == OFS_TX) begin
      d.rdata = 32'(q.txh);
    end else if (address == OFS_RX) begin
      d.rdata = 32'(q.rxh);
    end else begin
      d.rdata = 32'h0000_0000;
    end

    // register writes
    if (wr) begin
      if (address == OFS_MODE) begin
        d.mode = writedata[7:0];
      end else if (address == OFS_FMT) begin
        d.fmt = writedata[4:0];
      end else if (address == OFS_LEN) begin
        d.len = writedata[3:0];
      end else if (address == OFS_FLAG) begin
        if (!writedata[FLAG_TSF]) begin
          d.tsf = 1'b0;
          d.st = ST_IDLE;
          d.pend = 1'b0;
        end
        if (!writedata[FLAG_OVE]) begin
          d.ove = 1'b0;
        end
      end else if (address == OFS_TX) begin
        // single mode drops a write during a transfer
        if (pwr && txe && !(!cont && q.tsf)) begin
          d.txh = writedata[15:0];
          d.tx_full = 1'b1;
        end
      end
    end

    // reading rx frees it; in receive-only mode an idle read arms the unit
    if (rd && address == OFS_RX) begin
      d.rx_unread = 1'b0;
      if (pwr && rxe && !txe && q.st == ST_IDLE && !q.tsf) begin
        d.tsf = 1'b1;
        d.st = ST_RUN;
        d.cnt = nbits;
        d.sh = 16'h0000;
        d.pend = 1'b0;
      end
    end

    // first word of a transmit: holding register moves to the shifter
    if (d.tx_full && pwr && txe && q.st == ST_IDLE && !q.tsf) begin
      d.tsf = 1'b1;
      d.st = ST_RUN;
      d.cnt = nbits;
      d.sh = d.txh;
      d.tx_full = 1'b0;
      d.pend = 1'b0;
      d.irq_tx = cont;
    end

    // shifting on synchronised serial clock edges
    if (q.st == ST_RUN && smp_edge) begin
      d.si_bit = q.si_sync[1];
      d.pend = 1'b1;
      d.cnt = q.cnt - 5'd1;
      if (q.cnt == 5'd1) begin
        d.pend = 1'b0;
        word = shift_in(q.sh, q.si_sync[1], lsb_first, nbits)
               & ~(ALL_ONES << nbits);
        if (rxe) begin
          d.rxh = word;
          d.irq_rx = 1'b1;
          d.ove = d.ove | (cont & q.rx_unread);
          d.rx_unread = 1'b1;
        end else if (!cont) begin
          d.irq_rx = 1'b1;
        end
        if (!cont) begin
          d.st = ST_IDLE;
          d.tsf = 1'b0;
        end else if (txe) begin
          if (d.tx_full) begin
            d.sh = d.txh;
            d.tx_full = 1'b0;
            d.irq_tx = 1'b1;
            d.cnt = nbits;
          end else begin
            d.st = ST_HOLD;
          end
        end else if (q.mode[MC_SCE]) begin
          d.cnt = nbits;
        end else begin
          d.st = ST_HOLD;
        end
      end
    end else if (q.st == ST_RUN && drv_edge && q.pend) begin
      d.sh = shift_in(q.sh, q.si_bit, lsb_first, nbits);
      d.pend = 1'b0;
    end

    // unit off: transfer state dropped, configuration kept
    if (!pwr) begin
      d.st = ST_IDLE;
      d.tsf = 1'b0;
      d.tx_full = 1'b0;
      d.pend = 1'b0;
    end

    // output pin shows the bit at the head of the shifter while transmit is enabled and a transfer is active, else low
    if (txe && d.st != ST_IDLE) begin
      d.so = lsb_first ? d.sh[0] : d.sh[4'(nbits - 5'd1)];
    end else begin
      d.so = 1'b0;
    end
  end

  // all state in one register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.wreq <= 1'b1;
      q.sck_sync <= 3'h7; // idle clock is high, so no false edge at release
    end else begin
      q <= d;
    end
  end

  assign readdata = q.rdata;
  assign waitrequest = q.wreq;
  assign rx_done_irq = q.irq_rx;
  assign tx_ready_irq = q.irq_tx;
  assign lnk.serial_out_pin = q.so;
endmodule

// *** verification/csi_link_asserts.sv ***
module csi_link_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial link
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] lvl_q;

  // cycles since the serial clock last moved; saturates so idle is legal
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) lvl_q <= 5'h1f;
    else if ($changed(serial_clock_pin)) lvl_q <= 5'h00;
    else if (lvl_q != 5'h1f) lvl_q <= lvl_q + 5'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence sample_edge_s;
    $rose(serial_clock_pin);
  endsequence

  sequence drive_edge_s;
    $fell(serial_clock_pin);
  endsequence

  AST_SI_MOVES_LOW: assert property (
    $changed(serial_in_pin) |-> !serial_clock_pin)
    else $error("data in moved while clock high");
  AST_SO_SETTLED: assert property (
    sample_edge_s |-> $stable(serial_out_pin))
    else $error("data out moved at sample edge");
  AST_SO_HELD: assert property (
    sample_edge_s |=> $stable(serial_out_pin) [*2])
    else $error("data out moved right after sample edge");
  AST_SI_HELD: assert property (
    sample_edge_s |=> $stable(serial_in_pin) [*4])
    else $error("data in moved right after sample edge");
  AST_SCK_LOW_HALF: assert property (
    sample_edge_s |-> lvl_q inside {[14:16]})
    else $error("serial clock low level wrong length");
  AST_SCK_HIGH_MIN: assert property (
    drive_edge_s |-> lvl_q >= 5'd14)
    else $error("serial clock high level too short");
  AST_SCK_HIGH_RUN: assert property (
    sample_edge_s |=> serial_clock_pin [*8])
    else $error("serial clock high level too short");
  AST_SO_AFTER_DRIVE: assert property (
    $changed(serial_out_pin) && !serial_clock_pin |-> lvl_q <= 5'd8)
    else $error("data out moved late in low level");
endmodule

// *** verification/clocked_serial_slave_continuous_test.sv ***
module clocked_serial_slave_continuous_test
  import csi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr [2];
  logic rd [2];
  logic wr [2];
  logic [31:0] wd [2];
  wire [31:0] rdat [2];
  wire wt [2];
  wire rx_done_irq;
  wire tx_ready_irq;
  logic [31:0] q;
  int mismatches = 0;
  int cmp_count = 0;
  int rx_irqs = 0;
  int tx_irqs = 0;

  always #2.5 mclk = ~mclk;

  csi_link_if lnk ();
  clocked_serial_unit u_clocked_serial_unit (.mclk(mclk), .rst_n(rst_n),
    .address(addr[0]), .read(rd[0]), .write(wr[0]), .writedata(wd[0]),
    .readdata(rdat[0]), .waitrequest(wt[0]), .rx_done_irq(rx_done_irq),
    .tx_ready_irq(tx_ready_irq), .lnk(lnk.device));
  serial_master_end u_serial_master_end (.mclk(mclk), .rst_n(rst_n),
    .address(addr[1]), .read(rd[1]), .write(wr[1]), .writedata(wd[1]),
    .readdata(rdat[1]), .waitrequest(wt[1]), .lnk(lnk.master));
  csi_link_asserts u_csi_link_asserts (.mclk(mclk), .rst_n(rst_n),
    .serial_clock_pin(lnk.serial_clock_pin),
    .serial_in_pin(lnk.serial_in_pin),
    .serial_out_pin(lnk.serial_out_pin));

  // pulses are one cycle wide, so count them at every edge
  always @(posedge mclk) begin
    if (rx_done_irq === 1'b1) rx_irqs++;
    if (tx_ready_irq === 1'b1) tx_irqs++;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // four-bit value in reversed bit order, upper bits zero
  function automatic logic [31:0] rev4(input logic [7:0] v);
    return {28'h000_0000, v[0], v[1], v[2], v[3]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one avalon access on end s; held until waitrequest is seen low
  task automatic acc(input int s, input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge mclk);
    addr[s] <= a;
    wd[s] <= d;
    wr[s] <= w;
    rd[s] <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wt[s] !== 1'b0 && n < 50);
    r = rdat[s];
    wr[s] <= 1'b0;
    rd[s] <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic rchk(input int s, input logic [4:0] a, input logic [31:0] e);
    acc(s, 1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask

  // master clocks one word of its set length out; q returns what it shifted in
  task automatic msend(input logic [7:0] m);
    int n;
    acc(1, 1'b1, OFS_M_TX, {24'h00_0000, m}, q);
    n = 0;
    do begin
      acc(1, 1'b0, OFS_M_STAT, 32'h0000_0000, q);
      n++;
    end while (q[MSTAT_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin
      mismatches++;
      wrap_up();
    end
    acc(1, 1'b0, OFS_M_RX, 32'h0000_0000, q);
  endtask

  // model state is kept in plain integers beside the stimulus
  initial begin
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] txd [2];
    int e_rx;
    int e_tx;
    e_rx = 0;
    e_tx = 0;
    foreach (rd[i]) begin
      rd[i] = 1'b0;
      wr[i] = 1'b0;
      addr[i] = 5'h00;
      wd[i] = 32'h0000_0000;
    end
    void'($urandom(44931));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    acc(1, 1'b1, OFS_M_CTRL, 32'h0000_0000, q);
    acc(0, 1'b1, OFS_FMT, 32'h0000_0007, q);
    acc(0, 1'b1, OFS_LEN, 32'h0000_0000, q);
    acc(0, 1'b1, OFS_MODE, 32'h0000_00a3, q);
    rchk(0, OFS_MODE, 32'h0000_00a3);
    rchk(0, 5'h18, 32'h0000_0000);
    acc(0, 1'b0, OFS_RX, 32'h0000_0000, q);
    rchk(0, OFS_FLAG, 32'h0000_0080);
    // three words unread: the second and third overrun
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      msend(b);
      e_rx++;
      chk(rx_irqs, e_rx);
    end
    rchk(0, OFS_FLAG, 32'h0000_0081);
    rchk(0, OFS_RX, {24'h00_0000, b});
    acc(0, 1'b1, OFS_FLAG, 32'h0000_0080, q);
    rchk(0, OFS_FLAG, 32'h0000_0080);
    acc(0, 1'b1, OFS_MODE, 32'h0000_00a2, q);
    b = 8'($urandom);
    msend(b);
    e_rx++;
    chk(rx_irqs, e_rx);
    rchk(0, OFS_RX, {24'h00_0000, b});
    acc(0, 1'b1, OFS_FLAG, 32'h0000_0000, q);
    rchk(0, OFS_FLAG, 32'h0000_0000);
    acc(0, 1'b1, OFS_MODE, 32'h0000_0000, q);
    $display("test receive-only done");
    acc(0, 1'b1, OFS_MODE, 32'h0000_00e3, q);
    foreach (txd[i]) begin
      txd[i] = 8'($urandom);
      acc(0, 1'b1, OFS_TX, {24'h00_0000, txd[i]}, q);
    end
    e_tx++;
    rchk(0, OFS_FLAG, 32'h0000_0080);
    chk(tx_irqs, e_tx);
    // second word runs with no new write behind it
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      msend(b);
      chk(q, {24'h00_0000, txd[i]});
      e_rx++;
      if (i == 0) e_tx++;
      chk(rx_irqs, e_rx);
      chk(tx_irqs, e_tx);
      rchk(0, OFS_RX, {24'h00_0000, b});
    end
    acc(0, 1'b1, OFS_FLAG, 32'h0000_0000, q);
    rchk(0, OFS_FLAG, 32'h0000_0000);
    acc(0, 1'b1, OFS_MODE, 32'h0000_0000, q);
    $display("test transmit/receive done");
    acc(0, 1'b1, OFS_MODE, 32'h0000_00e0, q);
    acc(0, 1'b1, OFS_TX, 32'h0000_005a, q);
    acc(0, 1'b1, OFS_TX, 32'h0000_00c3, q);
    msend(8'h96);
    chk(q, 32'h0000_005a);
    e_rx++;
    chk(rx_irqs, e_rx);
    chk(tx_irqs, e_tx);
    acc(0, 1'b1, OFS_FLAG, 32'h0000_0000, q);
    msend(8'h69);
    chk(q, 32'h0000_0000);
    acc(0, 1'b1, OFS_MODE, 32'h0000_00c3, q);
    acc(0, 1'b1, OFS_TX, 32'h0000_00b1, q);
    e_tx++;
    msend(8'h3c);
    chk(q, 32'h0000_00b1);
    chk(rx_irqs, e_rx);
    chk(tx_irqs, e_tx);
    $display("test single and transmit-only done");
    // four-bit words, lsb first; the single-mode word is still unread
    acc(0, 1'b1, OFS_FLAG, 32'h0000_0000, q);
    acc(1, 1'b1, OFS_M_CTRL, 32'h0000_0004, q);
    acc(0, 1'b1, OFS_LEN, 32'h0000_0004, q);
    acc(0, 1'b1, OFS_MODE, 32'h0000_00f3, q);
    b = 8'($urandom) & 8'h0f;
    c = 8'($urandom) & 8'h0f;
    acc(0, 1'b1, OFS_TX, {24'h00_0000, b}, q);
    e_tx++;
    msend(c);
    chk(q, rev4(b));
    e_rx++;
    chk(rx_irqs, e_rx);
    chk(tx_irqs, e_tx);
    rchk(0, OFS_FLAG, 32'h0000_0081);
    rchk(0, OFS_RX, rev4(c));
    acc(0, 1'b1, OFS_FLAG, 32'h0000_0000, q);
    rchk(0, OFS_FLAG, 32'h0000_0000);
    $display("test short lsb-first done");
    wrap_up();
  end
endmodule
